// [lpmr_pkg.sv]
package lpmr_pkg;

	// Register offsets (byte addresses)
	localparam logic [11:0] LPMR_CMD_OFS    = 12'h000;
	localparam logic [11:0] LPMR_MODE_OFS   = 12'h004;
	localparam logic [11:0] LPMR_EXT_OFS    = 12'h008;
	localparam logic [11:0] LPMR_STAT_OFS   = 12'h00c;
	localparam logic [11:0] LPMR_BURST_OFS  = 12'h010;
	localparam logic [11:0] LPMR_COL_OFS    = 12'h014;

	// Command register fields
	localparam int LPMR_CMD_ADDR_LSB = 0;
	localparam int LPMR_ADDR_W       = 14;
	localparam int LPMR_CMD_BA_LSB   = 16;
	localparam int LPMR_CMD_CODE_LSB = 20;
	localparam int LPMR_CMD_CKE_BIT  = 24;

	// Mode register fields
	localparam int LPMR_BL_LSB   = 0;
	localparam int LPMR_BT_BIT   = 3;
	localparam int LPMR_RL_LSB   = 4;
	localparam int LPMR_OPM_LSB  = 7;

	localparam logic [2:0] LPMR_BL_2  = 3'h1;
	localparam logic [2:0] LPMR_BL_4  = 3'h2;
	localparam logic [2:0] LPMR_BL_8  = 3'h3;
	localparam logic [2:0] LPMR_BL_16 = 3'h4;
	localparam logic [2:0] LPMR_RL_2  = 3'h2;
	localparam logic [2:0] LPMR_RL_3  = 3'h3;

	localparam logic [13:0] LPMR_MODE_RST = 14'h0000;
	localparam logic [13:0] LPMR_EXT_RST  = 14'h0000;

	localparam logic [1:0] LPMR_BA_STD = 2'h0;
	localparam logic [1:0] LPMR_BA_EXT = 2'h2;

	typedef enum logic [3:0] {
		LPMR_CMD_NOP,
		LPMR_CMD_DESELECT,
		LPMR_CMD_ACTIVE,
		LPMR_CMD_READ,
		LPMR_CMD_WRITE,
		LPMR_CMD_BST,
		LPMR_CMD_PRECHARGE,
		LPMR_CMD_AREF,
		LPMR_CMD_MODE_LOAD
	} lpmr_cmd_t;

	typedef enum logic [2:0] {
		LPMR_PS_ACTIVE,
		LPMR_PS_PRE_PD,
		LPMR_PS_ACT_PD,
		LPMR_PS_SELF_REF,
		LPMR_PS_DEEP_PD
	} lpmr_pstate_t;

	// Column offset for beat k of a burst
	function automatic logic [3:0] lpmr_offset(
		input logic [3:0] start,
		input logic [3:0] k,
		input logic       interleaved,
		input logic [3:0] mask
	);
		logic [3:0] seq;
		seq = (start + k) & mask;
		return interleaved ? ((start ^ k) & mask) : seq;
	endfunction

	function automatic logic [3:0] lpmr_bl_mask(input logic [2:0] bl);
		case (bl)
			LPMR_BL_2:  return 4'h1;
			LPMR_BL_4:  return 4'h3;
			LPMR_BL_8:  return 4'h7;
			LPMR_BL_16: return 4'hf;
			default:    return 4'h0;
		endcase
	endfunction

endpackage

// [lpmr_cke_fsm.sv]
`timescale 1ns/1ps
module lpmr_cke_fsm
	import lpmr_pkg::*;
(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         step,
	input  wire logic         cke,
	input  wire lpmr_cmd_t    cmd,
	input  wire logic         banks_idle,
	output lpmr_pstate_t      pstate,
	output logic              dpd_exit,
	output logic              exit_viol
);

	logic         cke_prev_q, cke_prev_d;
	lpmr_pstate_t ps_q, ps_d;
	logic         dx_q, dx_d;
	logic         ev_q, ev_d;

	// Action from previous CKE, current CKE and current command
	always_comb begin
		ps_d       = ps_q;
		cke_prev_d = cke_prev_q;
		dx_d       = 1'b0;
		ev_d       = ev_q;
		if (step) begin
			cke_prev_d = cke;
			case ({cke_prev_q, cke})
				2'b10: begin
					if (cmd == LPMR_CMD_BST && banks_idle)
						ps_d = LPMR_PS_DEEP_PD;
					else if (cmd == LPMR_CMD_AREF && banks_idle)
						ps_d = LPMR_PS_SELF_REF;
					else if (banks_idle)
						ps_d = LPMR_PS_PRE_PD;
					else
						ps_d = LPMR_PS_ACT_PD;
				end
				2'b01: begin
					if (cmd != LPMR_CMD_NOP && cmd != LPMR_CMD_DESELECT)
						ev_d = 1'b1;
					if (ps_q == LPMR_PS_DEEP_PD)
						dx_d = 1'b1;
					ps_d = LPMR_PS_ACTIVE;
				end
				default: ps_d = ps_q;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cke_prev_q <= 1'b1;
			ps_q       <= LPMR_PS_ACTIVE;
			dx_q       <= 1'b0;
			ev_q       <= 1'b0;
		end else begin
			cke_prev_q <= cke_prev_d;
			ps_q       <= ps_d;
			dx_q       <= dx_d;
			ev_q       <= ev_d;
		end
	end

	assign pstate    = ps_q;
	assign dpd_exit  = dx_q;
	assign exit_viol = ev_q;

	property p_dpd_entry;
		@(posedge hclk) disable iff (!hresetn)
		step && cke_prev_q && !cke && cmd == LPMR_CMD_BST && banks_idle
			|=> ps_q == LPMR_PS_DEEP_PD;
	endproperty
	a_dpd_entry: assert property (p_dpd_entry) else $error("deep powerdown not entered");

	property p_hold_low;
		@(posedge hclk) disable iff (!hresetn)
		step && !cke_prev_q && !cke |=> ps_q == $past(ps_q);
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("power state moved with cke low");

endmodule // lpmr_cke_fsm

// [lpmr_burst_gen.sv]
`timescale 1ns/1ps
module lpmr_burst_gen
	import lpmr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        start,
	input  wire logic [9:0]  col,
	input  wire logic [2:0]  bl,
	input  wire logic        interleaved,
	output logic             busy,
	output logic [9:0]       col_out,
	output logic [3:0]       beat
);

	logic [3:0] k_q, k_d;
	logic [3:0] st_q, st_d;
	logic [9:0] blk_q, blk_d;
	logic [3:0] msk_q, msk_d;
	logic       it_q, it_d;
	logic       bz_q, bz_d;
	logic [3:0] off;

	assign off = lpmr_offset(st_q, k_q, it_q, msk_q);

	always_comb begin
		k_d   = k_q;
		st_d  = st_q;
		blk_d = blk_q;
		msk_d = msk_q;
		it_d  = it_q;
		bz_d  = bz_q;
		if (start) begin
			msk_d = lpmr_bl_mask(bl);
			blk_d = col & ~{6'h00, lpmr_bl_mask(bl)};
			st_d  = col[3:0] & lpmr_bl_mask(bl);
			it_d  = interleaved;
			k_d   = 4'h0;
			bz_d  = 1'b1;
		end else if (bz_q) begin
			k_d = k_q + 4'h1;
			if (k_q == msk_q)
				bz_d = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			k_q   <= 4'h0;
			st_q  <= 4'h0;
			blk_q <= 10'h000;
			msk_q <= 4'h0;
			it_q  <= 1'b0;
			bz_q  <= 1'b0;
		end else begin
			k_q   <= k_d;
			st_q  <= st_d;
			blk_q <= blk_d;
			msk_q <= msk_d;
			it_q  <= it_d;
			bz_q  <= bz_d;
		end
	end

	assign busy    = bz_q;
	assign col_out = blk_q | {6'h00, off};
	assign beat    = k_q;

	property p_in_block;
		@(posedge hclk) disable iff (!hresetn)
		bz_q |-> (col_out & ~{6'h00, msk_q}) == blk_q;
	endproperty
	a_in_block: assert property (p_in_block) else $error("burst left its block");

	property p_first_beat;
		@(posedge hclk) disable iff (!hresetn)
		start |=> col_out == (blk_q | {6'h00, st_q});
	endproperty
	a_first_beat: assert property (p_first_beat) else $error("first beat not start column");

	property p_seq_step;
		@(posedge hclk) disable iff (!hresetn)
		bz_q && !it_q && k_q != msk_q && !start
			|=> col_out[3:0] == (($past(col_out[3:0]) + 4'h1) & msk_q | (blk_q[3:0]));
	endproperty
	a_seq_step: assert property (p_seq_step) else $error("sequential order broken");

	property p_il_beat;
		@(posedge hclk) disable iff (!hresetn)
		bz_q && it_q |-> (col_out[3:0] & msk_q) == ((st_q ^ k_q) & msk_q);
	endproperty
	a_il_beat: assert property (p_il_beat) else $error("interleaved order broken");

endmodule // lpmr_burst_gen

// [lpmr_top.sv]
`timescale 1ns/1ps
module lpmr_top
	import lpmr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [13:0]      mode_reg,
	output logic [13:0]      ext_mode_reg,
	output logic             read_data_valid,
	output logic [9:0]       burst_col,
	output logic             burst_active
);

	// Bus data-phase capture
	logic        wr_q, wr_d;
	logic        rd_q, rd_d;
	logic [11:0] ofs_q, ofs_d;
	logic [31:0] rdat_q, rdat_d;
	logic        hrdy_q, hrdy_d;
	logic        bus_go;

	// Command strobe (one bus write to the command register = one clock edge of the memory)
	logic             step;
	logic             cke;
	lpmr_cmd_t        cmd;
	logic [1:0]       ba;
	logic [13:0]      addr;

	// Mode state
	logic [13:0] mode_q, mode_d;
	logic [13:0] ext_q, ext_d;
	logic        mwr_q, mwr_d;
	logic        mode_bad_q, mode_bad_d;
	logic [3:0]  rl_sh_q, rl_sh_d;
	logic        rdv_q, rdv_d;
	logic [9:0]  bcol_q, bcol_d;
	logic        bact_q, bact_d;
	logic        banks_idle_q, banks_idle_d;

	lpmr_pstate_t pstate;
	logic         dpd_exit;
	logic         exit_viol;
	logic         bg_busy;
	logic [9:0]   bg_col;
	logic [3:0]   bg_beat;
	logic         rd_or_wr;

	assign bus_go = hsel && hready && htrans[1];
	assign step   = wr_q && ofs_q == LPMR_CMD_OFS;
	assign addr   = hwdata[LPMR_CMD_ADDR_LSB +: LPMR_ADDR_W];
	assign ba     = hwdata[LPMR_CMD_BA_LSB +: 2];
	assign cmd    = lpmr_cmd_t'(hwdata[LPMR_CMD_CODE_LSB +: 4]);
	assign cke    = hwdata[LPMR_CMD_CKE_BIT];
	assign rd_or_wr = step && cke && (cmd == LPMR_CMD_READ || cmd == LPMR_CMD_WRITE);

	lpmr_cke_fsm u_cke (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.step       (step),
		.cke        (cke),
		.cmd        (cmd),
		.banks_idle (banks_idle_q),
		.pstate     (pstate),
		.dpd_exit   (dpd_exit),
		.exit_viol  (exit_viol)
	);

	lpmr_burst_gen u_burst (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.start       (rd_or_wr),
		.col         (addr[9:0]),
		.bl          (mode_q[LPMR_BL_LSB +: 3]),
		.interleaved (mode_q[LPMR_BT_BIT]),
		.busy        (bg_busy),
		.col_out     (bg_col),
		.beat        (bg_beat)
	);

	function automatic logic [31:0] rd_mux(input logic [11:0] o);
		case (o)
			LPMR_MODE_OFS:  return {18'h0_0000, mode_q};
			LPMR_EXT_OFS:   return {18'h0_0000, ext_q};
			LPMR_STAT_OFS:  return {26'h000_0000, exit_viol, mode_bad_q, banks_idle_q,
				pstate};
			LPMR_BURST_OFS: return {27'h000_0000, bg_busy, bg_beat};
			LPMR_COL_OFS:   return {22'h00_0000, bg_col};
			default:        return 32'h0000_0000;
		endcase
	endfunction

	always_comb begin
		wr_d         = bus_go && hwrite;
		rd_d         = bus_go && !hwrite;
		ofs_d        = bus_go ? haddr[11:0] : ofs_q;
		rdat_d       = rd_q ? rd_mux(ofs_q) : rdat_q;
		hrdy_d       = !(bus_go && !hwrite);
		mode_d       = mode_q;
		ext_d        = ext_q;
		mwr_d        = 1'b0;
		mode_bad_d   = mode_bad_q;
		banks_idle_d = banks_idle_q;
		if (step && cke && cmd == LPMR_CMD_MODE_LOAD && banks_idle_q) begin
			if (ba == LPMR_BA_STD) begin
				mode_d     = addr;
				mwr_d      = 1'b1;
				mode_bad_d = addr[LPMR_ADDR_W-1:LPMR_OPM_LSB] != '0;
			end else if (ba == LPMR_BA_EXT) begin
				ext_d = addr;
			end
		end
		if (step && cke && cmd == LPMR_CMD_ACTIVE)
			banks_idle_d = 1'b0;
		if (step && cke && cmd == LPMR_CMD_PRECHARGE && addr[10])
			banks_idle_d = 1'b1;
		if (dpd_exit) begin
			mode_d       = LPMR_MODE_RST;
			ext_d        = LPMR_EXT_RST;
			banks_idle_d = 1'b1;
		end
	end

	// Read latency pipeline: first data flagged 1 (RL 2) or 2 (RL 3) command edges after the read
	always_comb begin
		rl_sh_d = rl_sh_q;
		rdv_d   = 1'b0;
		if (step) begin
			rl_sh_d = {rl_sh_q[2:0], step && cke && cmd == LPMR_CMD_READ};
			case (mode_q[LPMR_RL_LSB +: 3])
				LPMR_RL_2: rdv_d = rl_sh_q[0];
				LPMR_RL_3: rdv_d = rl_sh_q[1];
				default:   rdv_d = 1'b0;
			endcase
		end
		bcol_d = bg_col;
		bact_d = bg_busy;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q         <= 1'b0;
			rd_q         <= 1'b0;
			ofs_q        <= 12'h000;
			rdat_q       <= 32'h0000_0000;
			hrdy_q       <= 1'b1;
			mode_q       <= LPMR_MODE_RST;
			ext_q        <= LPMR_EXT_RST;
			mwr_q        <= 1'b0;
			mode_bad_q   <= 1'b0;
			banks_idle_q <= 1'b1;
			rl_sh_q      <= 4'h0;
			rdv_q        <= 1'b0;
			bcol_q       <= 10'h000;
			bact_q       <= 1'b0;
		end else begin
			wr_q         <= wr_d;
			rd_q         <= rd_d;
			ofs_q        <= ofs_d;
			rdat_q       <= rdat_d;
			hrdy_q       <= hrdy_d;
			mode_q       <= mode_d;
			ext_q        <= ext_d;
			mwr_q        <= mwr_d;
			mode_bad_q   <= mode_bad_d;
			banks_idle_q <= banks_idle_d;
			rl_sh_q      <= rl_sh_d;
			rdv_q        <= rdv_d;
			bcol_q       <= bcol_d;
			bact_q       <= bact_d;
		end
	end

	assign hrdata          = rdat_q;
	assign hreadyout       = hrdy_q;
	assign hresp           = 1'b0;
	assign mode_reg        = mode_q;
	assign ext_mode_reg    = ext_q;
	assign read_data_valid = rdv_q;
	assign burst_col       = bcol_q;
	assign burst_active    = bact_q;

	property p_std_load;
		@(posedge hclk) disable iff (!hresetn)
		step && cke && cmd == LPMR_CMD_MODE_LOAD && ba == LPMR_BA_STD && banks_idle_q
			&& !dpd_exit |=> mode_q == $past(addr);
	endproperty
	a_std_load: assert property (p_std_load) else $error("standard register not loaded");

	property p_ext_only;
		@(posedge hclk) disable iff (!hresetn)
		step && cmd == LPMR_CMD_MODE_LOAD && ba == LPMR_BA_EXT && !dpd_exit
			|=> mode_q == $past(mode_q);
	endproperty
	a_ext_only: assert property (p_ext_only) else $error("extended load hit standard");

	property p_retain;
		@(posedge hclk) disable iff (!hresetn)
		!(step && cmd == LPMR_CMD_MODE_LOAD) && !dpd_exit |=> $stable(mode_q);
	endproperty
	a_retain: assert property (p_retain) else $error("mode register changed");

	property p_rl2;
		@(posedge hclk) disable iff (!hresetn)
		rdv_q && mode_q[LPMR_RL_LSB +: 3] == LPMR_RL_2 |-> $past(rl_sh_q[0]);
	endproperty
	a_rl2: assert property (p_rl2) else $error("latency two mistimed");

endmodule // lpmr_top

// [lpmr_ctrl_model.sv]
`timescale 1ns/1ps
module lpmr_ctrl_model
	import lpmr_pkg::*;
#(
	parameter int NOP_WAIT = 4
)(
	input  wire logic   hclk,
	input  wire logic   hready,
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata,
	output logic        hung
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		hung = 1'b0;
	end

	// Bounded wait for hready at a rising edge
	task automatic wt(inout int n);
		@(posedge hclk);
		while (hready !== 1'b1 && n < 64) begin
			@(posedge hclk);
			n++;
		end
	endtask

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {20'h0_0000, a};
		hsize <= 3'b010;
		wt(n);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : ~hwdata;
		wt(n);
		if (n >= 64) hung <= 1'b1;
	endtask

	// One bus write is one memory clock edge
	task automatic cmd(input lpmr_cmd_t k, input logic [1:0] ba, input logic [13:0] a,
		input logic e);
		xfer(1'b1, LPMR_CMD_OFS, {7'h00, e, k, 2'h0, ba, 2'h0, a});
	endtask

	task automatic nops(input int n, input logic e);
		repeat (n) cmd(LPMR_CMD_NOP, 2'h0, 14'h0000, e);
	endtask

	task automatic init_seq(input logic [13:0] m, input logic [13:0] x);
		nops(NOP_WAIT, 1'b1);
		cmd(LPMR_CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
		nops(NOP_WAIT, 1'b1);
		repeat (2) begin
			cmd(LPMR_CMD_AREF, 2'h0, 14'h0000, 1'b1);
			nops(NOP_WAIT, 1'b1);
		end
		cmd(LPMR_CMD_MODE_LOAD, LPMR_BA_EXT, x, 1'b1);
		nops(NOP_WAIT, 1'b1);
		cmd(LPMR_CMD_MODE_LOAD, LPMR_BA_STD, m, 1'b1);
		nops(NOP_WAIT, 1'b1);
	endtask
endmodule // lpmr_ctrl_model

// [lpddr_init_mode_burst_order_tb.sv]
`timescale 1ns/1ps
module lpddr_init_mode_burst_order_tb
	import lpmr_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel, hwrite, hready, hreadyout, hresp, hung;
	logic        read_data_valid, burst_active;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [13:0] mode_reg, ext_mode_reg;
	logic [9:0]  burst_col;
	logic        rd_ph = 1'b0;
	logic [63:0] rq[$];
	logic [9:0]  cq[$];
	int          fails = 0;
	int          n_compared = 0;
	int          n_rdv = 0;

	always #20 hclk = ~hclk;
	assign hready = hreadyout;

	lpmr_top lpmr_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mode_reg(mode_reg),
		.ext_mode_reg(ext_mode_reg), .read_data_valid(read_data_valid),
		.burst_col(burst_col), .burst_active(burst_active));
	lpmr_ctrl_model lpmr_ctrl_model_inst (.hclk(hclk), .hready(hready), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hung(hung));

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [63:0] note);
		n_compared++;
		if ((got & note[63:32]) !== note[31:0]) begin
			fails++;
			$display("wrong value at %0t: word %h expected %h", $time, got, note[31:0]);
		end
	endtask

	task automatic chk_col(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: column %h expected %h", $time, got, exp);
		end
	endtask

	// Result monitor
	always @(posedge hclk) begin
		if (read_data_valid === 1'b1) n_rdv++;
		if (rd_ph && hready === 1'b1) chk_word(hrdata, rq.pop_front());
		if (burst_active === 1'b1) chk_col(burst_col, cq.size() ? cq.pop_front() : 'x);
		if (hready === 1'b1) rd_ph <= hsel && htrans[1] && !hwrite;
	end

	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		rq.push_back({m, e & m});
		lpmr_ctrl_model_inst.xfer(1'b0, a, 32'h0000_0000);
	endtask

	task automatic c(input lpmr_cmd_t k, input logic [1:0] ba, input logic [13:0] a,
		input logic e);
		lpmr_ctrl_model_inst.cmd(k, ba, a, e);
	endtask

	function automatic logic [13:0] mv(input logic [2:0] bl, input logic bt);
		return {7'h00, bt ? LPMR_RL_3 : LPMR_RL_2, bt, bl};
	endfunction

	task automatic burst(input logic [2:0] bl, input logic bt);
		logic [9:0] col;
		logic [9:0] len;
		int         w;
		col = 10'($urandom());
		len = 10'h001 << bl;
		c(LPMR_CMD_MODE_LOAD, LPMR_BA_STD, mv(bl, bt), 1'b1);
		lpmr_ctrl_model_inst.nops(2, 1'b1);
		rd(LPMR_MODE_OFS, 32'hffff_ffff, {18'h0_0000, mv(bl, bt)});
		c(LPMR_CMD_ACTIVE, 2'h0, 14'h0000, 1'b1);
		for (int k = 0; k < 16; k++)
			if (k < len) cq.push_back((col & ~(len - 1))
				| ((bt ? col ^ 10'(k) : col + 10'(k)) & (len - 1)));
		n_rdv = 0;
		c((bl[0] ^ bt) ? LPMR_CMD_WRITE : LPMR_CMD_READ, 2'h0, {4'h0, col}, 1'b1);
		w = 0;
		while ((cq.size() != 0 || burst_active === 1'b1) && w < 100) begin
			@(posedge hclk);
			w++;
		end
		chk_word(32'(cq.size()), {32'hffff_ffff, 32'h0000_0000});
		cq.delete();
		c(LPMR_CMD_PRECHARGE, 2'h0, 14'h0400, 1'b1);
		lpmr_ctrl_model_inst.nops(2, 1'b1);
		chk_word(32'(n_rdv), {32'hffff_ffff, 31'h0000_0000, !(bl[0] ^ bt)});
	endtask

	lpmr_cmd_t    pk[5] = '{LPMR_CMD_NOP, LPMR_CMD_NOP, LPMR_CMD_AREF, LPMR_CMD_NOP,
		LPMR_CMD_BST};
	logic         pe[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	lpmr_pstate_t ps[5] = '{LPMR_PS_PRE_PD, LPMR_PS_ACTIVE, LPMR_PS_SELF_REF, LPMR_PS_ACTIVE,
		LPMR_PS_DEEP_PD};

	initial begin
		void'($urandom(1308));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd(LPMR_MODE_OFS, 32'hffff_ffff, 32'h0000_0000);
		rd(LPMR_EXT_OFS, 32'hffff_ffff, 32'h0000_0000);
		rd(12'h020, 32'hffff_ffff, 32'h0000_0000);
		lpmr_ctrl_model_inst.init_seq(mv(3'h2, 1'b0), 14'h0021);
		rd(LPMR_EXT_OFS, 32'hffff_ffff, 32'h0000_0021);
		rd(LPMR_MODE_OFS, 32'hffff_ffff, {18'h0_0000, mv(3'h2, 1'b0)});
		c(LPMR_CMD_MODE_LOAD, 2'h1, 14'h0000, 1'b1);
		lpmr_ctrl_model_inst.nops(2, 1'b1);
		rd(LPMR_MODE_OFS, 32'hffff_ffff, {18'h0_0000, mv(3'h2, 1'b0)});
		rd(LPMR_EXT_OFS, 32'hffff_ffff, 32'h0000_0021);
		for (int b = 1; b <= 4; b++)
			for (int t = 0; t < 2; t++)
				burst(3'(b), 1'(t));
		for (int i = 0; i < 5; i++) begin
			c(pk[i], 2'h0, 14'h0000, pe[i]);
			if (pe[i]) lpmr_ctrl_model_inst.nops(2, 1'b1);
			rd(LPMR_STAT_OFS, 32'h0000_0007, {29'h0000_0000, ps[i]});
			if (i == 3) rd(LPMR_MODE_OFS, 32'hffff_ffff, {18'h0_0000, mv(3'h4, 1'b1)});
		end
		c(LPMR_CMD_NOP, 2'h0, 14'h0000, 1'b1);
		lpmr_ctrl_model_inst.nops(2, 1'b1);
		rd(LPMR_MODE_OFS, 32'hffff_ffff, 32'h0000_0000);
		lpmr_ctrl_model_inst.init_seq(mv(3'h3, 1'b1), 14'h0003);
		rd(LPMR_MODE_OFS, 32'hffff_ffff, {18'h0_0000, mv(3'h3, 1'b1)});
		rd(LPMR_STAT_OFS, 32'h0000_0007, 32'h0000_0000);
		repeat (3) @(posedge hclk);
		tally_and_finish();
	end

	// Hang guards
	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		tally_and_finish();
	end

	always @(posedge hclk) begin
		if (hung) begin
			fails++;
			tally_and_finish();
		end
	end
endmodule // lpddr_init_mode_burst_order_tb
